// ===== core/dmdc_pkg.sv
// Constants, offsets and types for the memory decode and control block.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
// Overview of operation
// [R01] Protection status bit i means sector i protected
// [R02] Lock status register: bit 7 shows lock
// [R03] Lock readable by DSP, DSP writes ignored
// [R04] Locked device refuses programming tool access
// [R05] Only whole-device erase clears lock, leaves blank
// [R06] DSP flash reads served regardless of lock
// [R07] Single reset write resets flash, read array
// [R08] DSP issues reset after status, ID, error
// [R09] Reset ignored during program or bulk erase
// [R10] Reset aborts sector erase, back to read
// [R11] Read/write 8-bit page register at E0h
// [R12] Page outputs cleared to zero at reset
// [R13] Page outputs feed decode and general arrays
// [R14] Eight sector selects, three product terms each
// [R15] One select for 256-byte control block
// [R16] Three external chip selects, one term each
// [R17] Test-port select enables shared port C pins
// [R18] Fast bit clear: idle 70 ns enters standby
// [R19] Five bits block DSP controls from arrays
// [R20] Arrays share a 64-signal input bus
// [R21] DSP writes output cells, reads all cells
// [R22] Two groups of eight output macrocells
// [R23] Protection bits read-only to the DSP
// [R24] Reset write pattern is a confirmable constant
package dmdc_pkg;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int STANDBY_TIME_NS = 70;
  localparam int STANDBY_RAW     = STANDBY_TIME_NS / CLK_PERIOD_NS;
  localparam int STANDBY_CYC     = (STANDBY_RAW < 1) ? 1 : STANDBY_RAW;

  localparam int BUS_W     = 64;
  localparam int N_SEC     = 8;
  localparam int N_ECS     = 3;
  localparam int TERMS_SEC = 3;
  localparam int TERM_SEC  = 0;
  localparam int TERM_CSR  = N_SEC * TERMS_SEC;
  localparam int TERM_TEST = TERM_CSR + 1;
  localparam int TERM_ECS  = TERM_TEST + 1;
  localparam int N_TERMS   = TERM_ECS + N_ECS;
  localparam int BIT_CTL   = 16;
  localparam int N_BLOCK   = 5;
  localparam int LOCK_BIT  = 7;
  localparam int FAST_BIT  = 3;

  localparam logic [7:0] OFS_IMC_B  = 8'h18;
  localparam logic [7:0] OFS_IMC_C  = 8'h19;
  localparam logic [7:0] OFS_MC_AB  = 8'h20;
  localparam logic [7:0] OFS_MC_BC  = 8'h21;
  localparam logic [7:0] OFS_PMR0   = 8'hB0;
  localparam logic [7:0] OFS_PMR2   = 8'hB4;
  localparam logic [7:0] OFS_PROT   = 8'hC0;
  localparam logic [7:0] OFS_LOCK   = 8'hC2;
  localparam logic [7:0] OFS_PAGE   = 8'hE0;

  localparam logic [7:0] PAGE_RST   = 8'h00;
  localparam logic [7:0] PMR_RST    = 8'h00;
  localparam logic [7:0] MC_RST     = 8'h00;
  localparam logic [7:0] RESET_CODE = 8'hF0;

  typedef enum logic [1:0] {BUS_IDLE, BUS_RD, BUS_WR} dmdc_bus_e;
endpackage

// ===== core/dmdc_pterm.sv
// Product-term array: each term is a masked compare of the input bus.
// Assumes the care and match patterns are held stable by configuration.
`timescale 1ns/1ps
module dmdc_pterm
  import dmdc_pkg::*;
#(
  parameter int N = N_TERMS,
  parameter int W = BUS_W
) (
  input  wire logic [W-1:0]        in_bus,  // Shared array input bus
  input  wire logic [N-1:0][W-1:0] care,    // Bits each term looks at
  input  wire logic [N-1:0][W-1:0] match,   // Required value of cared bits
  output logic      [N-1:0]        hit      // Term true
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_term
      // An all-zero care pattern makes an always-true term
      assign hit[g] = ((in_bus ^ match[g]) & care[g]) == '0;
    end
  endgenerate
endmodule

// ===== core/dmdc_top.sv
// Runtime control section: page register, lock and protection status,
// flash reset command, decode selects, array input bus and macrocells.
// Assumes DSP pins are synchronous to clk and the flash engine is outside.
`timescale 1ns/1ps
module dmdc_top
  import dmdc_pkg::*;
#(
  parameter logic [7:0] RST_CODE = RESET_CODE
) (
  input  wire logic                            clk,              // 100 MHz clock
  input  wire logic                            srst,             // Sync reset, high
  input  wire logic [15:0]                     addr,             // DSP address
  input  wire logic [2:0]                      dsp_ctl_n,        // 0 wr, 1 rd, 2 aux
  input  wire logic [1:0]                      aux_ctl_n,        // Extra controls
  input  wire logic [7:0]                      data_in,          // Data pins in
  output logic      [7:0]                      data_out,         // Data pins out
  output logic                                 data_oe,          // Data drive
  input  wire logic [7:0]                      flash_rdata,      // Flash array data
  input  wire logic                            flash_prog_busy,  // Byte program
  input  wire logic                            flash_bulk_busy,  // Bulk erase
  input  wire logic                            flash_sect_busy,  // Sector erase
  output logic                                 flash_fsm_reset,  // Reset pulse
  output logic                                 flash_sect_abort, // Abort pulse
  input  wire logic                            lock_strap,       // Stored lock
  input  wire logic [7:0]                      prot_strap,       // Stored protect
  input  wire logic                            tool_req,         // Tool wants access
  output logic                                 tool_grant,       // Tool access ok
  input  wire logic                            tool_set_lock,    // Tool sets lock
  input  wire logic                            tool_prot_wr,     // Tool writes protect
  input  wire logic [7:0]                      tool_prot_data,   // New protect bits
  input  wire logic                            chip_erase_done,  // Whole erase done
  input  wire logic [N_TERMS-1:0][BUS_W-1:0]   cfg_care,         // Term care bits
  input  wire logic [N_TERMS-1:0][BUS_W-1:0]   cfg_match,        // Term match bits
  input  wire logic [7:0]                      pb_in,            // Port B inputs
  input  wire logic [7:0]                      pc_in,            // Port C inputs
  input  wire logic [2:0]                      pd_in,            // Port D inputs
  input  wire logic [7:0]                      mc_ab_d,          // Logic next AB
  input  wire logic [7:0]                      mc_ab_ld,         // Logic load AB
  input  wire logic [7:0]                      mc_bc_d,          // Logic next BC
  input  wire logic [7:0]                      mc_bc_ld,         // Logic load BC
  input  wire logic [7:0]                      bc_on_b,          // BC cell to port B
  output logic      [7:0]                      pb_out,           // Port B cell out
  output logic      [7:0]                      pc_out,           // Port C cell out
  output logic      [7:0]                      page_outputs,     // Page register
  output logic      [N_SEC-1:0]                sector_selects,   // Flash sectors
  output logic      [N_ECS-1:0]                external_chip_selects, // Port D
  output logic                                 csr_select,       // Control block
  output logic                                 testport_en,      // Port C test mode
  output logic      [BUS_W-1:0]                general_array_bus,// Array inputs
  output logic      [1:0]                      aux_ctl_gated_n,  // Gated extras
  output logic                                 pld_standby       // Arrays idle
);
  dmdc_bus_e        state_r, state_nxt;
  logic [7:0]       addr_q_r, addr_q_nxt;
  logic [7:0]       data_q_r, data_q_nxt;
  logic             csr_q_r, csr_q_nxt;
  logic             sec_q_r, sec_q_nxt;
  logic [7:0]       page_r, page_nxt;
  logic [7:0]       pmr0_r, pmr0_nxt;
  logic [7:0]       pmr2_r, pmr2_nxt;
  logic [7:0]       mc_ab_r, mc_ab_nxt;
  logic [7:0]       mc_bc_r, mc_bc_nxt;
  logic             lock_r, lock_nxt;
  logic [7:0]       prot_r, prot_nxt;
  logic             frst_r, frst_nxt;
  logic             fabt_r, fabt_nxt;
  logic [7:0]       dout_r, dout_nxt;
  logic             doe_r, doe_nxt;
  logic [BUS_W-1:0] bus_prev_r;
  logic [3:0]       idle_cnt_r, idle_cnt_nxt;
  logic             stby_r, stby_nxt;
  logic [N_SEC-1:0] sel_r;
  logic [N_ECS-1:0] ecs_r;
  logic             csr_r, test_r;
  logic [BUS_W-1:0] gbus_r;

  logic [N_TERMS-1:0] term_hit;
  logic [N_SEC-1:0]   sec_sel;
  logic [BUS_W-1:0]   array_bus;
  logic [2:0]         ctl_gated_n;
  logic               wr_act, rd_act, wr_commit, rst_cmd, csr_wr, flash_rdy;
  logic [7:0]         rsel;

  assign wr_act = ~dsp_ctl_n[0];
  assign rd_act = ~dsp_ctl_n[1];
  assign flash_rdy = ~(flash_prog_busy | flash_bulk_busy | flash_sect_busy);

  // Blocked DSP controls read as inactive inside the arrays only; blocked extras read as inactive at aux_ctl_gated_n
  assign ctl_gated_n     = dsp_ctl_n | pmr2_r[2:0];  // R19
  assign aux_ctl_gated_n = aux_ctl_n | pmr2_r[4:3];  // R19

  // Cells drive the arrays straight from their flops as feedback
  assign array_bus = {flash_rdy, mc_bc_r, mc_ab_r, page_r, pd_in, pc_in, pb_in,
                      srst, ctl_gated_n, addr};  // R20 R13

  dmdc_pterm #(
    .N (N_TERMS),
    .W (BUS_W)
  ) u_pterm (
    .in_bus (array_bus),
    .care   (cfg_care),
    .match  (cfg_match),
    .hit    (term_hit)
  );

  genvar g;
  generate
    for (g = 0; g < N_SEC; g++) begin : g_sec
      assign sec_sel[g] = |term_hit[TERM_SEC + g*TERMS_SEC +: TERMS_SEC];  // R14
    end
  endgenerate

  // Bus cycle tracking; a write takes effect at its trailing edge
  always_comb begin
    state_nxt  = state_r;
    addr_q_nxt = addr_q_r;
    data_q_nxt = data_q_r;
    csr_q_nxt  = csr_q_r;
    sec_q_nxt  = sec_q_r;
    case (state_r)
      BUS_IDLE: begin
        if (wr_act) begin
          state_nxt = BUS_WR;
        end else if (rd_act) begin
          state_nxt = BUS_RD;
        end
      end
      BUS_RD: begin
        if (!rd_act) begin
          state_nxt = BUS_IDLE;
        end
      end
      BUS_WR: begin
        if (!wr_act) begin
          state_nxt = BUS_IDLE;
        end
      end
      default: state_nxt = BUS_IDLE;
    endcase
    if (wr_act) begin
      addr_q_nxt = addr[7:0];
      data_q_nxt = data_in;
      csr_q_nxt  = term_hit[TERM_CSR];  // R15
      sec_q_nxt  = |sec_sel;
    end
  end

  assign wr_commit = (state_r == BUS_WR) && !wr_act;
  assign csr_wr    = wr_commit && csr_q_r;
  // Exact address pattern is left to the sector decode; only data is checked
  assign rst_cmd   = wr_commit && sec_q_r && (data_q_r == RST_CODE);  // R24 R07
  assign tool_grant = tool_req && !lock_r;  // R04

  always_comb begin
    case (addr[7:0])
      OFS_PAGE:  rsel = page_r;  // R11
      OFS_PROT:  rsel = prot_r;  // R01
      OFS_LOCK:  rsel = 8'(lock_r) << LOCK_BIT;  // R02 R03
      OFS_PMR0:  rsel = pmr0_r;
      OFS_PMR2:  rsel = pmr2_r;
      OFS_MC_AB: rsel = mc_ab_r;  // R21
      OFS_MC_BC: rsel = mc_bc_r;  // R21
      OFS_IMC_B: rsel = pb_in;  // R21
      OFS_IMC_C: rsel = pc_in;  // R21
      default:   rsel = 8'h00;
    endcase
  end

  // Register file, flash command and read path
  always_comb begin
    page_nxt  = page_r;
    pmr0_nxt  = pmr0_r;
    pmr2_nxt  = pmr2_r;
    lock_nxt  = lock_r;
    prot_nxt  = prot_r;
    frst_nxt  = 1'b0;
    fabt_nxt  = 1'b0;
    dout_nxt  = dout_r;
    doe_nxt   = 1'b0;
    // DSP loads win over the cells' own logic
    mc_ab_nxt = (mc_ab_d & mc_ab_ld) | (mc_ab_r & ~mc_ab_ld);
    mc_bc_nxt = (mc_bc_d & mc_bc_ld) | (mc_bc_r & ~mc_bc_ld);
    if (csr_wr) begin
      // Lock and protection offsets take no DSP write
      case (addr_q_r)
        OFS_PAGE:  page_nxt = data_q_r;  // R11
        OFS_PMR0:  pmr0_nxt = data_q_r;
        OFS_PMR2:  pmr2_nxt = data_q_r & 8'h1F;  // R19
        OFS_MC_AB: mc_ab_nxt = data_q_r;  // R21 R22
        OFS_MC_BC: mc_bc_nxt = data_q_r;  // R21 R22
        default: ;
      endcase
    end
    if (rst_cmd && !flash_prog_busy && !flash_bulk_busy) begin  // R09
      frst_nxt = 1'b1;  // R07
      fabt_nxt = flash_sect_busy;  // R10
    end
    // Whole erase blanks lock and protection; a tool write in the same cycle wins only if lock_r was already clear
    if (chip_erase_done) begin
      lock_nxt = 1'b0;  // R05
      prot_nxt = 8'h00;  // R05
    end
    if (tool_prot_wr && !lock_r) begin
      prot_nxt = tool_prot_data;  // R23 R04
    end
    if (tool_set_lock && !lock_r) begin
      lock_nxt = 1'b1;
    end
    if (rd_act && !wr_act) begin
      if (|sec_sel) begin
        dout_nxt = flash_rdata;  // R06
        doe_nxt  = 1'b1;
      end else if (term_hit[TERM_CSR]) begin
        dout_nxt = rsel;
        doe_nxt  = 1'b1;
      end
    end
  end

  // Standby timer: any change on the array inputs restarts it
  always_comb begin
    idle_cnt_nxt = idle_cnt_r;
    if (array_bus != bus_prev_r) begin
      idle_cnt_nxt = 4'h0;
    end else if (idle_cnt_r < 4'(STANDBY_CYC)) begin
      idle_cnt_nxt = idle_cnt_r + 4'h1;
    end
    stby_nxt = !pmr0_r[FAST_BIT] && (idle_cnt_nxt >= 4'(STANDBY_CYC));  // R18
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r    <= BUS_IDLE;
      addr_q_r   <= 8'h00;
      data_q_r   <= 8'h00;
      csr_q_r    <= 1'b0;
      sec_q_r    <= 1'b0;
      page_r     <= PAGE_RST;  // R12
      pmr0_r     <= PMR_RST;
      pmr2_r     <= PMR_RST;
      mc_ab_r    <= MC_RST;
      mc_bc_r    <= MC_RST;
      // Nonvolatile bits are caught from their straps under reset
      lock_r     <= lock_strap;
      prot_r     <= prot_strap;
      frst_r     <= 1'b0;
      fabt_r     <= 1'b0;
      dout_r     <= 8'h00;
      doe_r      <= 1'b0;
      bus_prev_r <= '0;
      idle_cnt_r <= 4'h0;
      stby_r     <= 1'b0;
      sel_r      <= '0;
      ecs_r      <= '0;
      csr_r      <= 1'b0;
      test_r     <= 1'b0;
      gbus_r     <= '0;
    end else begin
      state_r    <= state_nxt;
      addr_q_r   <= addr_q_nxt;
      data_q_r   <= data_q_nxt;
      csr_q_r    <= csr_q_nxt;
      sec_q_r    <= sec_q_nxt;
      page_r     <= page_nxt;
      pmr0_r     <= pmr0_nxt;
      pmr2_r     <= pmr2_nxt;
      mc_ab_r    <= mc_ab_nxt;
      mc_bc_r    <= mc_bc_nxt;
      lock_r     <= lock_nxt;
      prot_r     <= prot_nxt;
      frst_r     <= frst_nxt;
      fabt_r     <= fabt_nxt;
      dout_r     <= dout_nxt;
      doe_r      <= doe_nxt;
      bus_prev_r <= array_bus;
      idle_cnt_r <= idle_cnt_nxt;
      stby_r     <= stby_nxt;
      sel_r      <= sec_sel;  // R14
      ecs_r      <= term_hit[TERM_ECS +: N_ECS];  // R16
      csr_r      <= term_hit[TERM_CSR];  // R15
      test_r     <= term_hit[TERM_TEST];  // R17
      gbus_r     <= array_bus;  // R13
    end
  end

  assign data_out              = dout_r;
  assign data_oe               = doe_r;
  assign flash_fsm_reset       = frst_r;
  assign flash_sect_abort      = fabt_r;
  assign page_outputs          = page_r;
  assign sector_selects        = sel_r;
  assign external_chip_selects = ecs_r;
  assign csr_select            = csr_r;
  assign testport_en           = test_r;
  assign general_array_bus     = gbus_r;
  assign pld_standby           = stby_r;
  assign pc_out                = mc_bc_r;  // R22
  assign pb_out                = (mc_bc_r & bc_on_b) | (mc_ab_r & ~bc_on_b);  // R22

  a_page_reset: assert property (@(posedge clk) srst |=> page_outputs == 8'h00) // R12
    else $error("page not cleared by reset");
  a_page_write: assert property (@(posedge clk) disable iff (srst) // R11
    csr_wr && addr_q_r == OFS_PAGE |=> page_outputs == $past(data_q_r))
    else $error("page write lost");
  a_lock_dsp: assert property (@(posedge clk) disable iff (srst) // R03
    wr_commit && !chip_erase_done && !tool_set_lock |=> $stable(lock_r))
    else $error("DSP write changed lock");
  a_tool_block: assert property (@(posedge clk) disable iff (srst) // R04
    lock_r |-> !tool_grant)
    else $error("tool granted while locked");
  a_erase_clear: assert property (@(posedge clk) disable iff (srst) // R05
    chip_erase_done && !tool_set_lock && !tool_prot_wr |=> !lock_r && prot_r == 8'h00)
    else $error("erase did not blank lock");
  a_flash_read: assert property (@(posedge clk) disable iff (srst) // R06
    rd_act && !wr_act && |sec_sel |=> data_oe && data_out == $past(flash_rdata))
    else $error("flash read not served");
  a_rst_ignore: assert property (@(posedge clk) disable iff (srst) // R09
    rst_cmd && (flash_prog_busy || flash_bulk_busy) |=> !flash_fsm_reset)
    else $error("reset taken during program");
  a_sect_abort: assert property (@(posedge clk) disable iff (srst) // R10
    rst_cmd && flash_sect_busy && !flash_prog_busy && !flash_bulk_busy
    |=> flash_fsm_reset && flash_sect_abort)
    else $error("sector erase not aborted");
  a_rst_pulse: assert property (@(posedge clk) disable iff (srst) // R07
    flash_fsm_reset |=> !flash_fsm_reset)
    else $error("reset pulse too long");
  a_standby_on: assert property (@(posedge clk) disable iff (srst) // R18
    (!pmr0_r[FAST_BIT] && array_bus == bus_prev_r)[*8] |=> pld_standby)
    else $error("standby not entered");
  a_fast_awake: assert property (@(posedge clk) disable iff (srst) // R18
    pmr0_r[FAST_BIT] |=> !pld_standby)
    else $error("standby in fast mode");
  a_ctl_block: assert property (@(posedge clk) disable iff (srst) // R19
    pmr2_r[0] |-> array_bus[BIT_CTL])
    else $error("blocked control reached arrays");
  a_prot_ro: assert property (@(posedge clk) disable iff (srst) // R23
    !tool_prot_wr && !chip_erase_done |=> $stable(prot_r))
    else $error("protection changed by DSP");
endmodule

// ===== testbench/dmdc_dsp_model.sv
// DSP side of the bus: address, strobes and write data, moved on the falling edge.
// Assumes the device samples everything on the rising edge of clk.
`timescale 1ns/1ps
module dmdc_dsp_model (
  input  wire logic        clk,       // Bus clock
  output logic      [15:0] addr,      // DSP address
  output logic      [2:0]  dsp_ctl_n, // 0 wr, 1 rd, 2 aux
  output logic      [7:0]  data_in,   // Write data
  input  wire logic [7:0]  data_out,  // Read data
  input  wire logic        data_oe    // Device drives data
);
  initial begin
    addr = 16'h0000;
    dsp_ctl_n = 3'b111;
    data_in = 8'h00;
  end

  // Write is taken while wr is low and committed at the edge that sees it high
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    data_in = d;
    dsp_ctl_n[0] = 1'b0;
    @(negedge clk);
    dsp_ctl_n[0] = 1'b1;
    @(negedge clk);
    data_in = ~d; // A released bus must not keep showing the last byte
  endtask

  // Read strobe held over two edges so registered data has settled
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic oe);
    @(negedge clk);
    addr = a;
    dsp_ctl_n[1] = 1'b0;
    repeat (2) @(negedge clk);
    d = data_out;
    oe = data_oe;
    dsp_ctl_n[1] = 1'b1;
  endtask

  task automatic park(input logic [15:0] a);
    @(negedge clk);
    addr = a;
  endtask
endmodule

// ===== testbench/tb_dmdc_top.sv
// Self-checking bench for the decode and control block.
// Assumes the DSP bus model owns addr, strobes and write data.
`timescale 1ns/1ps
module tb_dmdc_top;
  import dmdc_pkg::*;
  localparam logic [15:0] CB_PAGE = {8'h01, OFS_PAGE};
  localparam logic [15:0] CB_PROT = {8'h01, OFS_PROT};
  localparam logic [15:0] CB_LOCK = {8'h01, OFS_LOCK};
  localparam logic [15:0] CB_PMR0 = {8'h01, OFS_PMR0};
  localparam logic [15:0] CB_PMR2 = {8'h01, OFS_PMR2};
  localparam logic [15:0] DA [8] = '{16'h8000, 16'h9123, 16'h4000, 16'h4000,
                                     16'h0100, 16'h0200, 16'h0300, 16'h7000};
  localparam logic [7:0]  DP [8] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [12:0] DE [8] = '{13'h0001, 13'h0001, 13'h0000, 13'h0002,
                                     13'h0800, 13'h1000, 13'h0100, 13'h0200};
  localparam logic [7:0]  PV [4] = '{8'h55, 8'hAA, 8'hFF, 8'h00};
  logic                          clk = 1'b0, srst = 1'b1, data_oe, tool_grant;
  logic                          flash_prog_busy, flash_bulk_busy, flash_sect_busy;
  logic                          flash_fsm_reset, flash_sect_abort, lock_strap, tool_req;
  logic                          tool_set_lock, tool_prot_wr, chip_erase_done;
  logic                          csr_select, testport_en, pld_standby;
  logic [15:0]                   addr;
  logic [2:0]                    dsp_ctl_n, pd_in, external_chip_selects;
  logic [1:0]                    aux_ctl_n, aux_ctl_gated_n;
  logic [7:0]                    data_in, data_out, flash_rdata, prot_strap, tool_prot_data;
  logic [7:0]                    pb_in, pc_in, mc_ab_d, mc_ab_ld, mc_bc_d, mc_bc_ld, bc_on_b;
  logic [7:0]                    pb_out, pc_out, page_outputs, sector_selects;
  logic [BUS_W-1:0]              general_array_bus;
  logic [N_TERMS-1:0][BUS_W-1:0] cfg_care, cfg_match;
  int                            err_total = 0, n_tests = 0, n_rst = 0, n_abt = 0;

  dmdc_top dut_u (.clk, .srst, .addr, .dsp_ctl_n, .aux_ctl_n, .data_in, .data_out,
    .data_oe, .flash_rdata, .flash_prog_busy, .flash_bulk_busy, .flash_sect_busy,
    .flash_fsm_reset, .flash_sect_abort, .lock_strap, .prot_strap, .tool_req, .tool_grant,
    .tool_set_lock, .tool_prot_wr, .tool_prot_data, .chip_erase_done, .cfg_care,
    .cfg_match, .pb_in, .pc_in, .pd_in, .mc_ab_d, .mc_ab_ld, .mc_bc_d, .mc_bc_ld,
    .bc_on_b, .pb_out, .pc_out, .page_outputs, .sector_selects, .external_chip_selects,
    .csr_select, .testport_en, .general_array_bus, .aux_ctl_gated_n, .pld_standby);
  dmdc_dsp_model dsp_u (.clk, .addr, .dsp_ctl_n, .data_in, .data_out, .data_oe);

  always #5 clk = ~clk;

  always @(posedge clk) begin
    // An unknown pulse counts as a pulse so that it cannot pass as none
    if (flash_fsm_reset !== 1'b0) n_rst++;
    if (flash_sect_abort !== 1'b0) n_abt++;
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       oe;
    dsp_u.rd(a, d, oe);
    check({oe, d}, {1'b1, e});
  endtask

  task automatic frst(input logic [15:0] a, input logic [7:0] d, input int er, input int ea);
    int r0;
    int a0;
    r0 = n_rst;
    a0 = n_abt;
    dsp_u.wr(a, d);
    repeat (4) @(negedge clk);
    check(n_rst - r0, er);
    check(n_abt - a0, ea);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic t_page;
    check(page_outputs, PAGE_RST);
    check({data_oe, csr_select, sector_selects}, 10'h000);
    for (int i = 0; i < 4; i++) begin
      dsp_u.wr(CB_PAGE, PV[i]);
      @(negedge clk);
      check(page_outputs, PV[i]);
      check(general_array_bus[46:39], PV[i]);
      rchk(CB_PAGE, PV[i]);
    end
    rchk({8'h01, 8'hF7}, 8'h00);
    dsp_u.wr(CB_PAGE, 8'hAA);
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    check(page_outputs, 8'h00);
  endtask

  task automatic t_secure;
    rchk(CB_PROT, 8'hA5);
    frst(16'h8000, RESET_CODE, 1, 0);
    rchk(CB_LOCK, 8'h00);
    tool_req = 1'b1;
    @(negedge clk);
    check(tool_grant, 1'b1);
    tool_prot_data = 8'h0F;
    pulse(tool_prot_wr);
    rchk(CB_PROT, 8'h0F);
    dsp_u.wr(CB_PROT, 8'hFF);
    rchk(CB_PROT, 8'h0F);
    pulse(tool_set_lock);
    rchk(CB_LOCK, 8'h80);
    check(tool_grant, 1'b0);
    dsp_u.wr(CB_LOCK, 8'h00);
    rchk(CB_LOCK, 8'h80);
    tool_prot_data = 8'hF0;
    pulse(tool_prot_wr);
    rchk(CB_PROT, 8'h0F);
    rchk(16'h8005, 8'h5A);
    flash_rdata = 8'hC6;
    rchk(16'h9005, 8'hC6);
    pulse(chip_erase_done);
    rchk(CB_LOCK, 8'h00);
    rchk(CB_PROT, 8'h00);
    check(tool_grant, 1'b1);
    tool_req = 1'b0;
  endtask

  task automatic t_flash;
    frst(16'h8000, 8'h12, 0, 0);
    frst(16'h0100, RESET_CODE, 0, 0);
    flash_prog_busy = 1'b1;
    frst(16'h9000, RESET_CODE, 0, 0);
    flash_prog_busy = 1'b0;
    flash_bulk_busy = 1'b1;
    frst(16'h8000, RESET_CODE, 0, 0);
    flash_bulk_busy = 1'b0;
    flash_sect_busy = 1'b1;
    frst(16'h8000, RESET_CODE, 1, 1);
    flash_sect_busy = 1'b0;
  endtask

  task automatic t_decode;
    for (int i = 0; i < 8; i++) begin
      dsp_u.wr(CB_PAGE, DP[i]);
      pd_in = (i == 7) ? 3'b001 : 3'b000;
      dsp_u.park(DA[i]);
      repeat (3) @(negedge clk);
      check(sector_selects, DE[i][7:0]);
      check(external_chip_selects, DE[i][10:8]);
      check(csr_select, DE[i][11]);
      check(testport_en, DE[i][12]);
      check({general_array_bus[46:36], general_array_bus[15:0]}, {DP[i], pd_in, DA[i]});
    end
  endtask

  task automatic t_power;
    repeat (12) @(negedge clk);
    check(pld_standby, 1'b1);
    pb_in = 8'h5A;
    repeat (2) @(negedge clk);
    check({pld_standby, general_array_bus[27:20]}, 9'h05A);
    dsp_u.wr(CB_PMR0, 8'h08);
    repeat (12) @(negedge clk);
    check(pld_standby, 1'b0);
    dsp_u.wr(CB_PMR0, 8'h00);
    aux_ctl_n = 2'b01;
    #1 check(aux_ctl_gated_n, 2'b01);
    dsp_u.wr(CB_PMR2, 8'h19);
    @(negedge clk);
    check(aux_ctl_gated_n, 2'b11);
    dsp_u.wr(CB_PMR2, 8'h00);
  endtask

  task automatic t_cells;
    dsp_u.wr({8'h01, OFS_MC_AB}, 8'h3C);
    dsp_u.wr({8'h01, OFS_MC_BC}, 8'hC3);
    @(negedge clk);
    check({pb_out, pc_out}, 16'h3CC3);
    rchk({8'h01, OFS_MC_AB}, 8'h3C);
    bc_on_b = 8'hF0;
    @(negedge clk);
    check(pb_out, 8'hCC);
    pb_in = 8'h96;
    pc_in = 8'h69;
    rchk({8'h01, OFS_IMC_B}, 8'h96);
    rchk({8'h01, OFS_IMC_C}, 8'h69);
    mc_ab_d = 8'h01;
    mc_ab_ld = 8'h05;
    mc_bc_ld = 8'h01;
    @(negedge clk);
    mc_ab_ld = 8'h00;
    mc_bc_ld = 8'h00;
    check(pc_out, 8'hC2);
    rchk({8'h01, OFS_MC_AB}, 8'h39);
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    {aux_ctl_n, flash_prog_busy, flash_bulk_busy, flash_sect_busy} = 5'b11000;
    {tool_req, tool_set_lock, tool_prot_wr, chip_erase_done, lock_strap} = 5'b00000;
    {flash_rdata, prot_strap, tool_prot_data} = {8'h5A, 8'hA5, 8'h00};
    {pb_in, pc_in, pd_in, bc_on_b} = '0;
    {mc_ab_d, mc_ab_ld, mc_bc_d, mc_bc_ld} = '0;
    for (int i = 0; i < N_TERMS; i++) begin
      cfg_care[i] = 64'h0000_0000_0008_0000; // Unused terms hit only during reset
      cfg_match[i] = 64'h0000_0000_0008_0000;
    end
    {cfg_care[0], cfg_match[0]} = {64'h0000_0000_0000_F000, 64'h0000_0000_0000_8000};
    {cfg_care[1], cfg_match[1]} = {64'h0000_0000_0000_F000, 64'h0000_0000_0000_9000};
    {cfg_care[3], cfg_match[3]} = {64'h0000_7F80_0000_F000, 64'h0000_0180_0000_4000};
    {cfg_care[24], cfg_match[24]} = {64'h0000_0000_0000_FF00, 64'h0000_0000_0000_0100};
    {cfg_care[25], cfg_match[25]} = {64'h0000_0000_0000_FF00, 64'h0000_0000_0000_0200};
    {cfg_care[26], cfg_match[26]} = {64'h0000_0000_0000_FF00, 64'h0000_0000_0000_0300};
    {cfg_care[27], cfg_match[27]} = {64'h0000_0010_0000_0000, 64'h0000_0010_0000_0000};
    repeat (4) @(negedge clk);
    srst = 1'b0;
    t_page;
    t_secure;
    t_flash;
    t_decode;
    t_power;
    t_cells;
    results;
  end

  initial begin
    #50_000;
    err_total++;
    results;
  end
endmodule
